//--- src/mirq_unit.sv
// interrupt entry unit of an 8-bit core: request sampling, disable flag,
// stack pushes and vector fetch.
// assumes the core pulses instrEnd at each instruction boundary and waits
// while busy is high; memory answers a read with data on the next cycle.
//
// Summary of operation
// - a low level on the maskable request input is a pending request, by level not edge.
// - the disable flag is set by command, by interrupt entry and by the start-up sequence.
// - with request low and disable clear the core enters and sets disable, else it waits.
// - a request held low while disable is set never causes a second entry.
// - there is no acknowledge; software finds the source by reading status registers.
// - commands set and clear the disable flag to block or re-enable requests.
// - entry loads the program counter from FFFE/FFFF, or FFFA/FFFB for non-maskable.
// - entry pushes pc high byte, pc low byte, then status, decrementing after each.
// - restoreStatus reloads disable from the status byte given, so restoring the pushed status returns disable to its level before entry.
// - a pending request is recognised only at the end of an instruction.
`timescale 1ns/100ps
module mirq_unit import mirq_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic irqPin_n,
  input wire logic nmiPin_n,
  input wire logic instrEnd,
  input wire logic [15:0] pcIn,
  input wire logic [7:0] statusIn,
  input wire logic [7:0] spIn,
  input wire logic setDisable,
  input wire logic clearDisable,
  input wire logic restoreStatus,
  input wire logic [7:0] restoredStatus,
  input wire logic [7:0] memRdata,
  output mirq_bus_t bus,
  output logic busy,
  output logic disableFlag,
  output logic newPcValid,
  output logic [15:0] newPc,
  output logic [7:0] spOut
);

  mirq_state_t state;
  mirq_state_t next_state;
  mirq_bus_t next_bus;
  logic irqLevel;
  logic nmiLevel;
  logic nmiPrev;
  logic nmiPending;
  logic isNmi;
  logic [15:0] pcHold;
  logic [7:0] statusHold;
  logic [7:0] spWork;
  logic [7:0] vecLow;
  logic next_nmiPending;
  logic next_isNmi;
  logic next_disableFlag;
  logic next_newPcValid;
  logic [15:0] next_newPc;
  logic [15:0] next_pcHold;
  logic [7:0] next_statusHold;
  logic [7:0] next_spWork;
  logic [7:0] next_vecLow;
  logic [7:0] next_spOut;
  logic takeIrq;
  logic takeNmi;
  logic [15:0] vecBase;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; request lines come from the wired board net
  mirq_sync3 #(.RESET_LEVEL(PIN_IDLE)) u_irqSync (
    .clk(clk),
    .rstn(rstn),
    .pin(irqPin_n),
    .level(irqLevel)
  );

  mirq_sync3 #(.RESET_LEVEL(PIN_IDLE)) u_nmiSync (
    .clk(clk),
    .rstn(rstn),
    .pin(nmiPin_n),
    .level(nmiLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // entry decision, only at a boundary while idle
  // no acknowledge goes back to peripherals; software polls status
  assign busy = (state != ST_IDLE);
  assign takeNmi = instrEnd && !busy && nmiPending;
  assign takeIrq = instrEnd && !busy && !nmiPending && !irqLevel && !disableFlag;
  assign vecBase = isNmi ? NMI_VEC : IRQ_VEC;

  // sequencer, flag and capture registers
  always_comb begin
    next_state = state;
    next_bus = '0;
    next_nmiPending = nmiPending;
    next_isNmi = isNmi;
    next_disableFlag = disableFlag;
    next_newPcValid = 1'b0;
    next_newPc = newPc;
    next_pcHold = pcHold;
    next_statusHold = statusHold;
    next_spWork = spWork;
    next_vecLow = vecLow;
    next_spOut = spOut;
    // software commands; entry and restore below take precedence
    if (!busy && setDisable) begin
      next_disableFlag = 1'b1;
    end else if (!busy && clearDisable) begin
      next_disableFlag = 1'b0;
    end
    if (!busy && restoreStatus) begin
      next_disableFlag = restoredStatus[IDIS_BIT];
    end
    unique case (state)
      ST_IDLE: begin
        if (takeNmi || takeIrq) begin
          next_state = ST_PUSH_HI;
          next_isNmi = takeNmi;
          next_pcHold = pcIn;
          next_statusHold = statusIn;
          next_statusHold[IDIS_BIT] = disableFlag;
          next_spWork = spIn - 8'h01;
          next_bus.wr = 1'b1;
          next_bus.addr = {STACK_PAGE, spIn};
          next_bus.data = pcIn[15:8];
          if (takeNmi) begin
            next_nmiPending = 1'b0;
          end
        end
      end
      ST_PUSH_HI: begin
        next_state = ST_PUSH_LO;
        next_spWork = spWork - 8'h01;
        next_bus.wr = 1'b1;
        next_bus.addr = {STACK_PAGE, spWork};
        next_bus.data = pcHold[7:0];
      end
      ST_PUSH_LO: begin
        next_state = ST_PUSH_P;
        next_spWork = spWork - 8'h01;
        next_bus.wr = 1'b1;
        next_bus.addr = {STACK_PAGE, spWork};
        next_bus.data = statusHold;
      end
      ST_PUSH_P: begin
        next_state = ST_VEC_LO;
        next_disableFlag = 1'b1;
        next_bus.rd = 1'b1;
        next_bus.addr = vecBase;
      end
      ST_VEC_LO: begin
        next_state = ST_VEC_HI;
        next_bus.rd = 1'b1;
        next_bus.addr = vecBase + 16'h0001;
      end
      ST_VEC_HI: begin
        next_state = ST_DONE;
        next_vecLow = memRdata;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
        next_newPc = {memRdata, vecLow};
        next_newPcValid = 1'b1;
        next_spOut = spWork;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // a falling edge wins over the clear made by taking an earlier one
    if (nmiPrev && !nmiLevel) begin
      next_nmiPending = 1'b1;
    end
  end

  // registers; start-up leaves requests blocked
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      bus <= '0;
      nmiPrev <= PIN_IDLE;
      nmiPending <= 1'b0;
      isNmi <= 1'b0;
      disableFlag <= IDIS_RESET;
      newPcValid <= 1'b0;
      newPc <= 16'h0000;
      pcHold <= 16'h0000;
      statusHold <= 8'h00;
      spWork <= 8'h00;
      vecLow <= 8'h00;
      spOut <= 8'h00;
    end else begin
      state <= next_state;
      bus <= next_bus;
      nmiPrev <= nmiLevel;
      nmiPending <= next_nmiPending;
      isNmi <= next_isNmi;
      disableFlag <= next_disableFlag;
      newPcValid <= next_newPcValid;
      newPc <= next_newPc;
      pcHold <= next_pcHold;
      statusHold <= next_statusHold;
      spWork <= next_spWork;
      vecLow <= next_vecLow;
      spOut <= next_spOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seqPushes(logic [7:0] sp0);
    bus.wr && bus.addr == {STACK_PAGE, sp0}
    ##1 bus.wr && bus.addr == {STACK_PAGE, sp0 - 8'h01} && bus.data == pcHold[7:0]
    ##1 bus.wr && bus.addr == {STACK_PAGE, sp0 - 8'h02} && bus.data == statusHold;
  endsequence

  sequence seqVector;
    bus.rd && bus.addr == vecBase ##1 bus.rd && bus.addr == vecBase + 16'h0001;
  endsequence

  a_level_take: assert property (takeIrq |=> state == ST_PUSH_HI && !isNmi)
    else $error("low request with disable clear not taken");
  a_masked_wait: assert property (instrEnd && !busy && disableFlag && !nmiPending
    |=> state == ST_IDLE)
    else $error("entry taken while disable set");
  a_entry_order: assert property (!busy && instrEnd && (takeIrq || takeNmi)
    |=> seqPushes($past(spIn)) ##1 seqVector ##2 newPcValid)
    else $error("entry push or vector order wrong");
  a_disable_entry: assert property (state == ST_PUSH_P |=> disableFlag [*3])
    else $error("disable not set by entry");
  a_vector_pick: assert property (state == ST_VEC_LO && isNmi |-> bus.addr == NMI_VEC)
    else $error("wrong vector for non-maskable");
  a_cmd_clear: assert property (!busy && clearDisable && !setDisable && !restoreStatus
    |=> !disableFlag)
    else $error("clear command ignored");
  a_restore_flag: assert property (!busy && restoreStatus
    |=> disableFlag == $past(restoredStatus[IDIS_BIT]))
    else $error("restore did not reload disable");
  a_boundary_only: assert property (state == ST_IDLE && !instrEnd |=> state == ST_IDLE)
    else $error("entry started off a boundary");
  a_new_pc: assert property (state == ST_VEC_HI |=> ##1 newPc[7:0] == $past(memRdata, 2))
    else $error("vector low byte lost");

endmodule // mirq_unit

//--- src/mirq_pkg.sv
// package for the maskable interrupt entry unit: vectors, stack page,
// status bit positions and the memory request carrier.
// assumes an 8-bit core with a 16-bit address bus and a stack in page one.
package mirq_pkg;

  // vector pairs, low byte at the even address
  localparam logic [15:0] IRQ_VEC = 16'hfffe;
  localparam logic [15:0] NMI_VEC = 16'hfffa;
  // stack page high byte
  localparam logic [7:0] STACK_PAGE = 8'h01;
  // position of the interrupt-disable flag inside the status byte
  localparam int IDIS_BIT = 2;
  // reset value of the disable flag: start-up runs with requests blocked
  localparam logic IDIS_RESET = 1'b1;
  // idle level of the active-low request pins
  localparam logic PIN_IDLE = 1'b1;

  // one memory access, driven for one cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } mirq_bus_t;

  // entry sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH_HI = 3'b001,
    ST_PUSH_LO = 3'b010,
    ST_PUSH_P = 3'b011,
    ST_VEC_LO = 3'b100,
    ST_VEC_HI = 3'b101,
    ST_DONE = 3'b110
  } mirq_state_t;

endpackage

//--- src/mirq_sync3.sv
// three-stage pin synchroniser with agreement filter.
// assumes the input is asynchronous to clk; output moves only when stages
// two and three agree.
`timescale 1ns/100ps
module mirq_sync3 import mirq_pkg::*; #(
  parameter logic RESET_LEVEL = PIN_IDLE
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  output logic level
);

  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // filtered level follows once the last two stages agree
  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  // s1 feeds only s2, so a metastable sample never reaches logic
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end

endmodule // mirq_sync3

//--- tb/mirq_periph_model.sv
// peripheral stand-in: status flag in bit 7 and an open-collector request output.
// assumes a pull-up on the shared request line in the bench.
`timescale 1ns/100ps
module mirq_periph_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic raise,
  input wire logic wrStatus,
  input wire logic rdData,
  output logic [7:0] status,
  output wire logic irqOut_n
);
  logic [7:0] next_status;
  ////////////////////////////////////////////////////////////////////////////////
  // flag holds until serviced; a status read never touches it
  always_comb begin
    next_status = status;
    if (raise) next_status[7] = 1'b1;
    if (wrStatus || rdData) next_status[7] = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (!rstn) status <= 8'h00;
    else status <= next_status;
  end
  // pulls low only, so several of these share one line; released as the flag clears
  assign irqOut_n = status[7] ? 1'b0 : 1'bz;
endmodule // mirq_periph_model

//--- tb/tb_maskable_irq_handshake.sv
// self-checking bench for the interrupt entry unit with two peripheral models.
// assumes one read cycle of memory latency and a pulled-up shared request line.
`timescale 1ns/100ps
module tb_maskable_irq_handshake import mirq_pkg::*;;
  logic clk, rstn, nmiPin_n, instrEnd, setDisable, clearDisable, restoreStatus;
  logic [15:0] pcIn, newPc;
  logic [7:0] statusIn, spIn, restoredStatus, memRdata, vecLo, vecHi, spOut;
  logic [1:0] raise, wrStatus, rdData;
  logic [7:0] stat [2];
  logic busy, disableFlag, newPcValid;
  mirq_bus_t bus;
  wire irqLine;
  int errorCnt, checksDone;
  pullup (irqLine);
  ////////////////////////////////////////////////////////////////////////////////
  mirq_unit DUT (.clk(clk), .rstn(rstn), .irqPin_n(irqLine), .nmiPin_n(nmiPin_n),
    .instrEnd(instrEnd), .pcIn(pcIn), .statusIn(statusIn), .spIn(spIn),
    .setDisable(setDisable), .clearDisable(clearDisable), .restoreStatus(restoreStatus),
    .restoredStatus(restoredStatus), .memRdata(memRdata), .bus(bus), .busy(busy),
    .disableFlag(disableFlag), .newPcValid(newPcValid), .newPc(newPc), .spOut(spOut));
  for (genvar g = 0; g < 2; g++) begin : gPer
    mirq_periph_model P (.clk(clk), .rstn(rstn), .raise(raise[g]), .wrStatus(wrStatus[g]),
      .rdData(rdData[g]), .status(stat[g]), .irqOut_n(irqLine));
  end
  // vector memory answers one cycle after the read; idle data is junk on purpose
  always @(posedge clk) memRdata <= bus.rd ? (bus.addr[0] ? vecHi : vecLo) : 8'hc3;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (e !== g) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (errorCnt == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one-cycle core command: 0 set, 1 clear, 2 restore, 3 boundary
  task automatic pulse(input int k, input logic [7:0] rs);
    {setDisable, clearDisable, restoreStatus, instrEnd} = 4'(8 >> k);
    restoredStatus = rs;
    @(negedge clk);
    {setDisable, clearDisable, restoreStatus, instrEnd} = 4'h0;
  endtask
  // six-cycle peripheral action on device n: 0 raise, 1 status write, 2 data read
  task automatic poke(input int k, input int n);
    raise[n] = (k == 0);
    wrStatus[n] = (k == 1);
    rdData[n] = (k == 2);
    repeat (6) @(negedge clk);
    {raise, wrStatus, rdData} = 6'h00;
  endtask
  // boundary pulse that must not start an entry
  task automatic no_entry();
    pulse(3, 8'h00);
    repeat (3) begin
      chk("busy", 0, busy);
      chk("bus", 0, bus);
      @(negedge clk);
    end
  endtask
  // full entry walk from a boundary pulse
  // dis is the disable level the bench expects at the boundary, saved in the pushed status
  task automatic entry(input logic [15:0] pc, input logic [7:0] sp, input logic nmi,
    input logic dis);
    mirq_bus_t e [6];
    logic [15:0] v;
    v = nmi ? NMI_VEC : IRQ_VEC;
    pcIn = pc;
    spIn = sp;
    e[0] = '{1'b0, 1'b1, {STACK_PAGE, sp}, pc[15:8]};
    e[1] = '{1'b0, 1'b1, {STACK_PAGE, sp - 8'h01}, pc[7:0]};
    e[2] = '{1'b0, 1'b1, {STACK_PAGE, sp - 8'h02}, statusIn};
    e[2].data[IDIS_BIT] = dis;
    e[3] = '{1'b1, 1'b0, v, 8'h00};
    e[4] = '{1'b1, 1'b0, v + 16'h0001, 8'h00};
    e[5] = '0;
    pulse(3, 8'h00);
    chk("busy", 1, busy);
    for (int i = 0; i < 6; i++) begin
      chk("bus", e[i].rd ? {e[i][25:8], 8'h00} : e[i],
        bus.rd ? {bus[25:8], 8'h00} : bus);
      @(negedge clk);
    end
    chk("valid", 1, newPcValid);
    chk("newPc", {vecHi, vecLo}, newPc);
    // cut to eight bits so a wrap below zero stays inside the stack page
    chk("spOut", 8'(sp - 8'h03), spOut);
    chk("disable", 1, disableFlag);
    chk("busy", 0, busy);
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, instrEnd, setDisable, clearDisable, restoreStatus} = 5'h00;
    {raise, wrStatus, rdData} = 6'h00;
    {nmiPin_n, pcIn, statusIn, spIn, restoredStatus} = {1'b1, 16'h0, 8'ha1, 8'hff, 8'h0};
    {vecLo, vecHi} = 16'h3412;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    chk("disable", 1, disableFlag);
    chk("bus", 0, bus);
    poke(0, 0);
    no_entry();
    pulse(1, 8'h00);
    chk("disable", 0, disableFlag);
    entry(16'hbeef, 8'hff, 1'b0, 1'b0);
    no_entry();
    chk("status", 8'h80, stat[0]);
    poke(0, 1);
    poke(1, 0);
    no_entry();
    pulse(2, 8'h00);
    chk("disable", 0, disableFlag);
    repeat (8) @(negedge clk);
    chk("busy", 0, busy);
    {vecLo, vecHi} = 16'h8756;
    entry(16'h01fe, 8'h01, 1'b0, 1'b0);
    poke(2, 1);
    chk("status", 8'h00, stat[1]);
    chk("line", 1, irqLine);
    // clear first so the restore below must itself raise the flag
    pulse(1, 8'h00);
    pulse(2, 8'h04);
    chk("disable", 1, disableFlag);
    pulse(1, 8'h00);
    pulse(0, 8'h00);
    chk("disable", 1, disableFlag);
    nmiPin_n = 1'b0;
    repeat (6) @(negedge clk);
    {vecLo, vecHi} = 16'hcdab;
    entry(16'h7f00, 8'h80, 1'b1, 1'b1);
    summarize();
  end
  initial begin
    #100000;
    errorCnt++;
    summarize();
  end
endmodule // tb_maskable_irq_handshake
